// ==== fcs_asserts.sv ====
// Concurrent checks on the byte link between the host end and the controller end.
`timescale 1ns/1ns
module fcs_asserts (
  input wire logic clock_i, // core clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic wr_strobe, // host byte write pulse
  input wire logic [7:0] wr_byte, // byte from host
  input wire logic rd_strobe, // host byte read pulse
  input wire logic [7:0] rd_byte, // result byte
  input wire logic rqm, // controller ready
  input wire logic dio, // 1 = controller to host
  input wire logic busy, // controller not idle
  input wire logic irq, // completion interrupt
  input wire logic step_i // head step pulse
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic lock_q;
  wire op_take = wr_strobe && rqm && !dio && !busy;
  wire sense_take = op_take && wr_byte == 8'h08;
  // The requested lock state is kept so the result byte can be judged later.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_q <= 1'b0;
    end else if (op_take) begin
      lock_q <= wr_byte[7];
    end
  end
  chk_reset_idle: assert property ($rose(arst_n_i) |-> rqm && !dio && !busy && !irq)
    else $error("link not idle after reset");
  chk_lock_reply: assert property (op_take && (wr_byte & 8'h7f) == 8'h14 |=>
    ##[0:3] (rqm && dio && rd_byte == {3'h0, lock_q, 4'h0})) else $error("lock reply wrong");
  chk_sense_clear: assert property (sense_take |=> !irq)
    else $error("interrupt not cleared by sense");
  chk_irq_hold: assert property (irq && !sense_take |=> irq)
    else $error("interrupt dropped without sense");
  chk_sense_status: assert property (sense_take && irq |=>
    ##[0:3] (rqm && dio && (rd_byte & 8'hf8) == 8'h20)) else $error("sense status wrong");
  chk_sense_empty: assert property (sense_take && !irq |=>
    ##[0:3] (rqm && dio && rd_byte == 8'h80)) else $error("empty sense reply wrong");
  chk_step_busy: assert property (step_i |-> busy && !rqm)
    else $error("step outside a head move");
  chk_result_hold: assert property (rqm && dio && !rd_strobe |=> $stable(rd_byte))
    else $error("result byte changed before read");
endmodule

// ==== fcs_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the floppy command set.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_CLK_NS 40
`define FCS_STEP_NS 3000
`define FCS_STEP_CYC ((`FCS_STEP_NS) / (`FCS_CLK_NS))
`define FCS_CMD_FORMAT 8'h0d
`define FCS_MASK_DENS 8'hbf
`define FCS_CMD_RECAL 8'h07
`define FCS_CMD_SENSE 8'h08
`define FCS_CMD_SPECIFY 8'h03
`define FCS_CMD_SEEK 8'h0f
`define FCS_CMD_CONFIG 8'h13
`define FCS_CMD_RSEEK 8'h8f
`define FCS_MASK_DIR 8'hbf
`define FCS_CMD_DUMP 8'h0e
`define FCS_CMD_PERP 8'h12
`define FCS_CMD_LOCK 8'h14
`define FCS_MASK_LOCK 8'h7f
`define FCS_LOCK_BIT 7
`define FCS_RSEEK_DIR_BIT 6
`define FCS_LOCK_RES_BIT 4
`define FCS_ST0_SEEK_END 8'h20
`define FCS_ST0_NO_INT 8'h80
`define FCS_PERP_OW_BIT 7
`define FCS_FMT_RES_N 4'h7
`define FCS_DUMP_RES_N 4'ha
`define FCS_REG_CMD 8'h00
`define FCS_REG_RES 8'h04
`define FCS_REG_STAT 8'h08
`define FCS_REG_ISTAT 8'h0c
`define FCS_REG_IMASK 8'h10
`define FCS_INT_DEV 0
`define FCS_INT_RES 1
`define FCS_INT_CMD 2
`define FCS_IMASK_RST 3'h0
`endif

// ==== fcs_dev.sv ====
// Controller end: command decode, parameter capture, head movement and result bytes.
// Contract
// - Format: opcode, drive/head, four params, IDs, results.
// - Recalibrate steps out to track zero, interrupts.
// - Sense interrupt: 08h, returns status and cylinder.
// - Sense reports the last finished head move.
// - Seek 0Fh, drive/head, target cylinder, moves head.
// - Specify 03h, step/unload byte, load/non-DMA byte.
// - Configure 13h, zero byte, flags/threshold, precomp cylinder.
// - Relative seek: bit7, direction bit6, unsigned count.
// - Register dump returns ten internal state bytes.
// - Perpendicular 12h with overwrite, drive, gap bits.
// - Lock returns requested lock state in bit4.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "fcs_cfg.svh"
module fcs_dev import fcs_pkg::*; #(
  parameter int STEP_CYC = `FCS_STEP_CYC
) (
  input wire logic clock_i, // core clock
  input wire logic arst_n_i, // asynchronous reset, active low
  fcs_if.dev link, // byte link to the host
  input wire logic trk0_i, // selected drive reports cylinder zero
  output logic [1:0] drive_sel_o, // selected drive
  output logic head_select_o, // selected head
  output logic step_o, // one-cycle step pulse
  output logic step_dir_o, // 1 steps inward
  output logic non_dma_o // non-DMA mode chosen by specify
);
  fcs_state_t st_q;
  fcs_op_t op_q;
  logic [7:0] cmd_q;
  logic [7:0] pbuf_q [0:4];
  logic [2:0] pcnt_q;
  logic [9:0] idcnt_q;
  logic [3:0] ridx_q;
  logic [7:0] pcn_q [0:3];
  logic [7:0] tgt_q;
  logic [15:0] tmr_q;
  logic [3:0] step_rate_time_q, head_unload_time_q;
  logic [6:0] head_load_time_q;
  logic implied_seek_en_q, queue_disable_q, poll_disable_q;
  logic [3:0] queue_threshold_q;
  logic [7:0] precomp_start_cyl_q, final_sector_number_q;
  logic lock_q, overwrite_enable_q, gap_mode_q, write_gate_mode_q;
  logic [3:0] perp_drive_q;
  logic irq_q, sense_ok_q;
  logic [7:0] sis_st0_q, sis_pcn_q;
  logic step_q, dir_q, head_q;
  logic [1:0] drv_q;

  function automatic fcs_op_t decode(input logic [7:0] b);
    if ((b & `FCS_MASK_DENS) == `FCS_CMD_FORMAT) return OP_FMT;
    if (b == `FCS_CMD_RECAL) return OP_RECAL;
    if (b == `FCS_CMD_SENSE) return OP_SENSE;
    if (b == `FCS_CMD_SPECIFY) return OP_SPEC;
    if (b == `FCS_CMD_SEEK) return OP_SEEK;
    if (b == `FCS_CMD_CONFIG) return OP_CONF;
    if ((b & `FCS_MASK_DIR) == `FCS_CMD_RSEEK) return OP_RSEEK;
    if (b == `FCS_CMD_DUMP) return OP_DUMP;
    if (b == `FCS_CMD_PERP) return OP_PERP;
    if ((b & `FCS_MASK_LOCK) == `FCS_CMD_LOCK) return OP_LOCK;
    return OP_NONE;
  endfunction

  function automatic logic [2:0] n_params(input fcs_op_t op);
    case (op)
      OP_FMT: return 3'd5;
      OP_RECAL, OP_PERP: return 3'd1;
      OP_SPEC, OP_SEEK, OP_RSEEK: return 3'd2;
      OP_CONF: return 3'd3;
      default: return 3'd0;
    endcase
  endfunction

  wire fcs_op_t in_op = decode(link.wr_byte);
  wire [2:0] in_np = n_params(in_op);
  wire [1:0] p_drv = pbuf_q[0][1:0];
  wire [7:0] cur_pcn = pcn_q[drv_q];
  wire [9:0] id_total = {pbuf_q[2], 2'b00};
  // A relative move starts from the drive named in the command, not the last one moved.
  wire [8:0] rs_up = {1'b0, pcn_q[p_drv]} + {1'b0, pbuf_q[1]};
  wire [7:0] rs_dn = (pcn_q[p_drv] > pbuf_q[1]) ? pcn_q[p_drv] - pbuf_q[1] : 8'h00;
  wire [7:0] rs_tgt = cmd_q[`FCS_RSEEK_DIR_BIT] ? (rs_up[8] ? 8'hff : rs_up[7:0]) : rs_dn;
  wire tick = (tmr_q == 16'(STEP_CYC - 1));
  wire move_done = (op_q == OP_RECAL) ? trk0_i : (cur_pcn == tgt_q);

  logic [3:0] n_res;
  logic [7:0] res_byte;
  always_comb begin
    n_res = 4'd1;
    res_byte = 8'h00;
    unique case (op_q)
      OP_FMT: begin
        n_res = `FCS_FMT_RES_N;
        res_byte = (ridx_q == 4'd0) ? {5'b0_0000, head_q, drv_q} : 8'h00;
      end
      OP_SENSE: begin
        n_res = sense_ok_q ? 4'd2 : 4'd1;
        if (!sense_ok_q) res_byte = `FCS_ST0_NO_INT;
        else res_byte = (ridx_q == 4'd0) ? sis_st0_q : sis_pcn_q;
      end
      OP_LOCK: begin
        res_byte = 8'h00;
        res_byte[`FCS_LOCK_RES_BIT] = lock_q;
      end
      OP_DUMP: begin
        n_res = `FCS_DUMP_RES_N;
        case (ridx_q)
          4'd0, 4'd1, 4'd2, 4'd3: res_byte = pcn_q[ridx_q[1:0]];
          4'd4: res_byte = {step_rate_time_q, head_unload_time_q};
          4'd5: res_byte = {head_load_time_q, non_dma_o};
          4'd6: res_byte = final_sector_number_q;
          4'd7: res_byte = {lock_q, 1'b0, perp_drive_q, gap_mode_q, write_gate_mode_q};
          4'd8: res_byte = {1'b0, implied_seek_en_q, queue_disable_q, poll_disable_q,
                            queue_threshold_q};
          4'd9: res_byte = precomp_start_cyl_q;
          default: res_byte = 8'h00;
        endcase
      end
      default: begin
        n_res = 4'd1;
        res_byte = 8'h00;
      end
    endcase
  end

  // Host may hand over a byte only while the ready flag shows the right direction.
  assign link.rqm = st_q inside {S_CMD, S_PARAM, S_FMT, S_RES};
  assign link.dio = (st_q == S_RES);
  assign link.busy = (st_q != S_CMD);
  assign link.irq = irq_q;
  assign link.rd_byte = res_byte;
  assign drive_sel_o = drv_q;
  assign head_select_o = head_q;
  assign step_o = step_q;
  assign step_dir_o = dir_q;

  wire take_wr = link.wr_strobe && link.rqm && !link.dio;
  wire take_rd = link.rd_strobe && link.dio;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_CMD;
      op_q <= OP_NONE;
      cmd_q <= 8'h00;
      pcnt_q <= 3'd0;
      idcnt_q <= 10'd0;
      ridx_q <= 4'd0;
      tgt_q <= 8'h00;
      tmr_q <= 16'h0000;
      for (int i = 0; i < 5; i++) pbuf_q[i] <= 8'h00;
      for (int i = 0; i < 4; i++) pcn_q[i] <= 8'h00;
      step_rate_time_q <= 4'h0;
      head_unload_time_q <= 4'h0;
      head_load_time_q <= 7'h00;
      non_dma_o <= 1'b0;
      implied_seek_en_q <= 1'b0;
      queue_disable_q <= 1'b0;
      poll_disable_q <= 1'b0;
      queue_threshold_q <= 4'h0;
      precomp_start_cyl_q <= 8'h00;
      final_sector_number_q <= 8'h00;
      lock_q <= 1'b0;
      overwrite_enable_q <= 1'b0;
      perp_drive_q <= 4'h0;
      gap_mode_q <= 1'b0;
      write_gate_mode_q <= 1'b0;
      irq_q <= 1'b0;
      sense_ok_q <= 1'b0;
      sis_st0_q <= 8'h00;
      sis_pcn_q <= 8'h00;
      step_q <= 1'b0;
      dir_q <= 1'b0;
      head_q <= 1'b0;
      drv_q <= 2'd0;
    end else begin
      step_q <= 1'b0;
      unique case (st_q)
        S_CMD: begin
          // Unknown opcodes are dropped so the controller stays ready for a command.
          if (take_wr && in_op != OP_NONE) begin
            op_q <= in_op;
            cmd_q <= link.wr_byte;
            pcnt_q <= 3'd0;
            st_q <= (in_np == 3'd0) ? S_LAUNCH : S_PARAM;
            if (in_op == OP_SENSE) begin
              sense_ok_q <= irq_q;
              irq_q <= 1'b0;
            end
          end
        end
        S_PARAM: begin
          if (take_wr) begin
            pbuf_q[pcnt_q] <= link.wr_byte;
            pcnt_q <= pcnt_q + 3'd1;
            if (pcnt_q == n_params(op_q) - 3'd1) st_q <= S_LAUNCH;
          end
        end
        S_LAUNCH: begin
          ridx_q <= 4'd0;
          idcnt_q <= 10'd0;
          tmr_q <= 16'h0000;
          st_q <= S_RES;
          unique case (op_q)
            OP_SPEC: begin
              {step_rate_time_q, head_unload_time_q} <= pbuf_q[0];
              {head_load_time_q, non_dma_o} <= pbuf_q[1];
              st_q <= S_CMD;
            end
            OP_CONF: begin
              {implied_seek_en_q, queue_disable_q, poll_disable_q} <= pbuf_q[1][6:4];
              queue_threshold_q <= pbuf_q[1][3:0];
              precomp_start_cyl_q <= pbuf_q[2];
              st_q <= S_CMD;
            end
            OP_PERP: begin
              overwrite_enable_q <= pbuf_q[0][`FCS_PERP_OW_BIT];
              if (pbuf_q[0][`FCS_PERP_OW_BIT]) perp_drive_q <= pbuf_q[0][5:2];
              {gap_mode_q, write_gate_mode_q} <= pbuf_q[0][1:0];
              st_q <= S_CMD;
            end
            OP_LOCK: lock_q <= cmd_q[`FCS_LOCK_BIT];
            OP_SEEK, OP_RECAL, OP_RSEEK: begin
              drv_q <= p_drv;
              head_q <= pbuf_q[0][2];
              tgt_q <= (op_q == OP_RSEEK) ? rs_tgt : pbuf_q[1];
              st_q <= S_MOVE;
            end
            OP_FMT: begin
              drv_q <= p_drv;
              head_q <= pbuf_q[0][2];
              final_sector_number_q <= pbuf_q[2];
              st_q <= (pbuf_q[2] == 8'h00) ? S_RES : S_FMT;
            end
            default: st_q <= S_RES;
          endcase
        end
        S_FMT: begin
          // Four ID bytes per sector; the track write itself happens on the drive side.
          if (take_wr) begin
            idcnt_q <= idcnt_q + 10'd1;
            if (idcnt_q == id_total - 10'd1) st_q <= S_RES;
          end
        end
        S_MOVE: begin
          tmr_q <= tick ? 16'h0000 : tmr_q + 16'h0001;
          if (tick) begin
            if (move_done) begin
              if (op_q == OP_RECAL) pcn_q[drv_q] <= 8'h00;
              sis_st0_q <= `FCS_ST0_SEEK_END | {5'b0_0000, head_q, drv_q};
              sis_pcn_q <= (op_q == OP_RECAL) ? 8'h00 : cur_pcn;
              irq_q <= 1'b1;
              st_q <= S_CMD;
            end else begin
              step_q <= 1'b1;
              dir_q <= (op_q != OP_RECAL) && (tgt_q > cur_pcn);
              if (op_q != OP_RECAL && tgt_q > cur_pcn) pcn_q[drv_q] <= cur_pcn + 8'h01;
              else if (cur_pcn != 8'h00) pcn_q[drv_q] <= cur_pcn - 8'h01;
            end
          end
        end
        S_RES: begin
          if (take_rd) begin
            ridx_q <= ridx_q + 4'd1;
            if (ridx_q == n_res - 4'd1) st_q <= S_CMD;
          end
        end
      endcase
    end
  end
endmodule

// ==== fcs_host.sv ====
// Host end: APB registers that feed command bytes and collect result bytes.
`timescale 1ns/1ns
`include "fcs_cfg.svh"
module fcs_host import fcs_pkg::*; (
  input wire logic clock_i, // core clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  output logic irq_o, // level interrupt
  fcs_if.host link // byte link to the controller
);
  logic tx_full_q, rx_full_q, dev_irq_q;
  logic [7:0] tx_byte_q, rx_byte_q;
  logic [2:0] istat_q, imask_q;

  wire acc = psel_i && penable_i;
  wire wr_acc = acc && pwrite_i;
  wire rd_acc = acc && !pwrite_i;
  wire sel_cmd = (paddr_i == `FCS_REG_CMD);
  wire sel_res = (paddr_i == `FCS_REG_RES);
  wire sel_stat = (paddr_i == `FCS_REG_STAT);
  wire sel_istat = (paddr_i == `FCS_REG_ISTAT);
  wire sel_imask = (paddr_i == `FCS_REG_IMASK);

  // A byte moves only when the controller is ready in that direction.
  wire send = tx_full_q && link.rqm && !link.dio;
  wire fetch = !rx_full_q && link.rqm && link.dio;
  wire [2:0] ev = {send, fetch, link.irq && !dev_irq_q};
  wire [2:0] clr_bits = (rd_acc && sel_istat) ? prdata_o[2:0] : 3'h0;

  assign link.wr_strobe = send;
  assign link.wr_byte = tx_byte_q;
  assign link.rd_strobe = fetch;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign irq_o = |(istat_q & imask_q);

  wire [31:0] rd_mux = sel_res ? {24'h00_0000, rx_byte_q} :
                       sel_stat ? {26'h000_0000, link.irq, link.busy, link.dio, link.rqm,
                                   rx_full_q, tx_full_q} :
                       sel_istat ? {29'h0000_0000, istat_q} :
                       sel_imask ? {29'h0000_0000, imask_q} : 32'h0000_0000;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      dev_irq_q <= 1'b0;
      tx_byte_q <= 8'h00;
      rx_byte_q <= 8'h00;
      istat_q <= 3'h0;
      imask_q <= `FCS_IMASK_RST;
      prdata_o <= 32'h0000_0000;
    end else begin
      dev_irq_q <= link.irq;
      // Writes while the byte slot is full are dropped; software polls status first.
      if (wr_acc && sel_cmd && !tx_full_q) begin
        tx_full_q <= 1'b1;
        tx_byte_q <= pwdata_i[7:0];
      end else if (send) begin
        tx_full_q <= 1'b0;
      end
      if (fetch) begin
        rx_full_q <= 1'b1;
        rx_byte_q <= link.rd_byte;
      end else if (rd_acc && sel_res) begin
        rx_full_q <= 1'b0;
      end
      if (wr_acc && sel_imask) imask_q <= pwdata_i[2:0];
      // A read clears only the bits it returned, so an event caught during the read
      // stays pending; new events also win over the clear in the same cycle.
      istat_q <= (istat_q & ~clr_bits) | ev;
      if (psel_i && !penable_i) prdata_o <= rd_mux;
    end
  end
endmodule

// ==== fcs_if.sv ====
// Byte link between the host end and the controller end.
`timescale 1ns/1ns
interface fcs_if;
  logic wr_strobe;
  logic [7:0] wr_byte;
  logic rd_strobe;
  logic [7:0] rd_byte;
  logic rqm;
  logic dio;
  logic busy;
  logic irq;
  modport dev (input wr_strobe, wr_byte, rd_strobe, output rd_byte, rqm, dio, busy, irq);
  modport host (output wr_strobe, wr_byte, rd_strobe, input rd_byte, rqm, dio, busy, irq);
endinterface

// ==== fcs_pkg.sv ====
// Types shared by both ends of the floppy command set link.
package fcs_pkg;
  typedef enum logic [5:0] {
    S_CMD = 6'b00_0001,
    S_PARAM = 6'b00_0010,
    S_LAUNCH = 6'b00_0100,
    S_FMT = 6'b00_1000,
    S_MOVE = 6'b01_0000,
    S_RES = 6'b10_0000
  } fcs_state_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_FMT, OP_RECAL, OP_SENSE, OP_SPEC, OP_SEEK,
    OP_CONF, OP_RSEEK, OP_DUMP, OP_PERP, OP_LOCK
  } fcs_op_t;
endpackage

// ==== floppy_cmd_set_part_two_tb.sv ====
// Self-checking bench joining the host end and the controller end.
`timescale 1ns/1ns
`include "fcs_cfg.svh"
module floppy_cmd_set_part_two_tb;
  logic clock_i, arst_n_i, psel, penable, pwrite, trk0, pready, pslverr, irq_o;
  logic step, step_dir, non_dma, head_sel;
  logic [1:0] drive_sel;
  logic [7:0] paddr, cyl_q;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] dump_exp [10] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h21, 8'h03, 8'h00, 8'h8d,
    8'h57, 8'h09};
  int n_mismatch = 0;
  int samples_checked = 0;
  fcs_if u_link ();
  fcs_host i_fcs_host (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq_o), .link(u_link));
  fcs_dev #(.STEP_CYC(2)) i_fcs_dev (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(u_link),
    .trk0_i(trk0), .drive_sel_o(drive_sel), .head_select_o(head_sel), .step_o(step),
    .step_dir_o(step_dir), .non_dma_o(non_dma));
  fcs_asserts i_fcs_asserts (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .wr_strobe(u_link.wr_strobe), .wr_byte(u_link.wr_byte), .rd_strobe(u_link.rd_strobe),
    .rd_byte(u_link.rd_byte), .rqm(u_link.rqm), .dio(u_link.dio), .busy(u_link.busy),
    .irq(u_link.irq), .step_i(step));
  // One physical head is shared by all drives, so track zero follows the last moves.
  assign trk0 = (cyl_q == 8'h00);
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) cyl_q <= 8'h00;
    else if (step === 1'b1) cyl_q <= step_dir ? cyl_q + 8'h01 : cyl_q - 8'h01;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // No local wait limit: a slave that never answers is caught by the watchdog.
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(`FCS_REG_STAT, 1'b0, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 200);
    if (rd[b] !== v) chk(n, 0);
  endtask
  task automatic put(input logic [7:0] b);
    apb(`FCS_REG_CMD, 1'b1, {24'h00_0000, b});
    poll(0, 1'b0);
  endtask
  task automatic pull();
    poll(1, 1'b1);
    apb(`FCS_REG_RES, 1'b0, 32'h0000_0000);
  endtask
  task automatic get(input logic [7:0] e);
    pull();
    chk(rd, {24'h00_0000, e});
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (u_link.irq !== 1'b1 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    @(posedge clock_i);
    chk(u_link.irq, 1'b1);
  endtask
  task automatic t_reset();
    apb(`FCS_REG_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(8'h14, 1'b1, 32'hffff_ffff);
    apb(8'h14, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(pslverr, 1'b0);
    put(8'hff);
    apb(`FCS_REG_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
  endtask
  task automatic t_lock();
    for (int l = 0; l < 2; l++) begin
      put({l[0], 7'h14});
      get({3'h0, l[0], 4'h0});
    end
  endtask
  task automatic t_seek();
    put(8'h03);
    put(8'h21);
    put(8'h03);
    chk(non_dma, 1'b1);
    apb(`FCS_REG_IMASK, 1'b1, 32'h0000_0001);
    apb(`FCS_REG_ISTAT, 1'b0, 32'h0000_0000);
    put(8'h0f);
    put(8'h05);
    put(8'h03);
    wait_irq();
    chk({irq_o, cyl_q, head_sel, drive_sel}, {1'b1, 8'h03, 3'h5});
    apb(`FCS_REG_ISTAT, 1'b0, 32'h0000_0000);
    // The clearing read lands at the access edge, so the level is judged one edge later.
    @(posedge clock_i);
    chk({rd[0], irq_o}, 2'b10);
    put(8'h08);
    get(8'h25);
    get(8'h03);
    put(8'h08);
    get(8'h80);
  endtask
  task automatic t_move(input logic [7:0] op, input logic [7:0] n, input logic [7:0] cyl);
    put(op);
    put(8'h00);
    if (op != 8'h07) put(n);
    wait_irq();
    chk(irq_o, 1'b0);
    put(8'h08);
    get(8'h20);
    get(cyl);
  endtask
  task automatic t_dump();
    put(8'h13);
    put(8'h00);
    put(8'h57);
    put(8'h09);
    put(8'h12);
    put(8'h8d);
    put(8'h0e);
    for (int i = 0; i < 10; i++) begin
      pull();
      chk(rd, {24'h00_0000, dump_exp[i]});
    end
  endtask
  task automatic t_format();
    put(8'h4d);
    put(8'h00);
    put(8'h02);
    put(8'h02);
    put(8'h1b);
    put(8'he5);
    for (int i = 0; i < 8; i++) put(8'(i));
    for (int i = 0; i < 7; i++) get(8'h00);
    apb(`FCS_REG_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
  endtask
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    {arst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_lock();
    t_seek();
    apb(`FCS_REG_IMASK, 1'b1, 32'h0000_0000);
    t_move(8'hcf, 8'h02, 8'h02);
    t_move(8'h8f, 8'h01, 8'h01);
    t_move(8'h07, 8'h00, 8'h00);
    chk(cyl_q, 8'h00);
    t_dump();
    t_format();
    results();
  end
  // Far longer than the full sequence needs, so only a hang reaches it.
  initial begin
    #2_000_000;
    n_mismatch++;
    results();
  end
endmodule
